// *** hdl/event_flags.sv ***
module event_flags #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    input  wire logic [WIDTH-1:0] mask_i,
    output logic      [WIDTH-1:0] flags_o,
    output logic                  irq_o
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;
    logic             irq_q;
    logic             irq_d;

    always_comb begin
        // Set wins over the read clear
        flags_d = set_i | (flags_q & ~clr_i);
        irq_d   = |(flags_d & mask_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q   <= irq_d;
        end
    end

    assign flags_o = flags_q;
    assign irq_o   = irq_q;

endmodule

// *** hdl/interrupt_pending_status_bank.sv ***
// Our own choice: register access over Wishbone.
module interrupt_pending_status_bank #(
    parameter int unsigned NCH = pending_pkg::NUM_CH
) (
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [pending_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [pending_pkg::SEL_W-1:0]   wb_sel_i,
    input  wire logic [pending_pkg::DAT_W-1:0]   wb_dat_i,
    output logic      [pending_pkg::DAT_W-1:0]   wb_dat_o,
    output logic                                 wb_ack_o,
    input  wire logic [NCH-1:0]                  interrupt_channel_i,
    output logic                                 maskable_request_out_o,
    output logic                                 irq_o
);

    // ****************************************
    // Bus request capture
    // ****************************************
    pending_pkg::wb_req_t req;

    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we  = wb_we_i;
    assign req.adr = wb_adr_i;
    assign req.sel = wb_sel_i;
    assign req.dat = wb_dat_i;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [7:0] stat_byte(
        input logic [31:0] pend,
        input logic [1:0]  idx
    );
        return pend[idx*8 +: 8];
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    pending_pkg::bus_state_t state_q;
    pending_pkg::bus_state_t state_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic [31:0] mode_q;
    logic [31:0] mode_d;
    logic [31:0] pol_q;
    logic [31:0] pol_d;
    logic [31:0] en_q;
    logic [31:0] en_d;
    logic [1:0]  evtmsk_q;
    logic [1:0]  evtmsk_d;
    logic        mreq_q;
    logic        mreq_d;

    logic [31:0] pend;
    logic [31:0] edge_hit;
    logic [31:0] ovr_hit;
    logic [31:0] clr;
    logic [1:0]  evt_clr;
    logic [1:0]  evt_set;
    logic [1:0]  evt_flags;
    logic [5:0]  idx;
    logic        commit;
    logic        is_stat;

    assign idx     = req.adr[7:2];
    assign commit  = (state_q == pending_pkg::BUS_ACK) && req.cyc && req.stb;
    assign is_stat = (idx <= pending_pkg::IDX_STAT3);

    // ****************************************
    // Channel cells
    // ****************************************
    assign pend[0]     = 1'b0;
    assign edge_hit[0] = 1'b0;
    assign ovr_hit[0]  = 1'b0;

    for (genvar c = 1; c < 32; c++) begin : g_ch
        pending_channel u_ch (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .src_i  (interrupt_channel_i[c]),
            .mode_i (mode_q[c]),
            .pol_i  (pol_q[c]),
            .clr_i  (clr[c]),
            .pend_o (pend[c]),
            .edge_o (edge_hit[c]),
            .ovr_o  (ovr_hit[c])
        );
    end

    // W1C only lands on edge-mode channels; level ones ignore it
    always_comb begin
        clr = '0;
        if (commit && req.we && is_stat && req.sel[0]) begin
            clr[idx[1:0]*8 +: 8] = req.dat[7:0];
        end
        clr = clr & mode_q & pending_pkg::CH_VALID;
    end

    // ****************************************
    // Event flags and interrupt
    // ****************************************
    always_comb begin
        evt_set = '0;
        evt_set[pending_pkg::EVT_EDGE_POS] = |edge_hit;
        evt_set[pending_pkg::EVT_OVR_POS]  = |ovr_hit;
        evt_clr = '0;
        // Clear only what the read returned, so nothing arriving meanwhile is lost
        if (commit && !req.we && idx == pending_pkg::IDX_EVT) begin
            evt_clr = dat_q[1:0];
        end
    end

    event_flags #(
        .WIDTH (pending_pkg::EVT_W)
    ) u_evt (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (evt_set),
        .clr_i   (evt_clr),
        .mask_i  (evtmsk_q),
        .flags_o (evt_flags),
        .irq_o   (irq_o)
    );

    // ****************************************
    // Bus state, read data and control registers
    // ****************************************
    always_comb begin
        state_d  = state_q;
        ack_d    = 1'b0;
        dat_d    = dat_q;
        mode_d   = mode_q;
        pol_d    = pol_q;
        en_d     = en_q;
        evtmsk_d = evtmsk_q;
        case (state_q)
            pending_pkg::BUS_IDLE: begin
                if (req.cyc && req.stb) begin
                    state_d = pending_pkg::BUS_ACK;
                    ack_d   = 1'b1;
                    dat_d   = '0;
                    if (is_stat) begin
                        // Mask never touches what is reported
                        dat_d[7:0] = stat_byte(pend, idx[1:0]);
                    end else if (idx == pending_pkg::IDX_MODE) begin
                        dat_d = mode_q & pending_pkg::CH_VALID;
                    end else if (idx == pending_pkg::IDX_POL) begin
                        dat_d = pol_q & pending_pkg::CH_VALID;
                    end else if (idx == pending_pkg::IDX_ENABLE) begin
                        dat_d = en_q & pending_pkg::CH_VALID;
                    end else if (idx == pending_pkg::IDX_EVT) begin
                        dat_d[1:0] = evt_flags;
                    end else if (idx == pending_pkg::IDX_EVTMSK) begin
                        dat_d[1:0] = evtmsk_q;
                    end
                end
            end
            pending_pkg::BUS_ACK: begin
                state_d = pending_pkg::BUS_IDLE;
                if (commit && req.we) begin
                    if (idx == pending_pkg::IDX_MODE) begin
                        mode_d = merge_bytes(mode_q, req.dat, req.sel);
                    end else if (idx == pending_pkg::IDX_POL) begin
                        pol_d = merge_bytes(pol_q, req.dat, req.sel);
                    end else if (idx == pending_pkg::IDX_ENABLE) begin
                        en_d = merge_bytes(en_q, req.dat, req.sel);
                    end else if (idx == pending_pkg::IDX_EVTMSK && req.sel[0]) begin
                        evtmsk_d = req.dat[1:0];
                    end
                end
            end
            default: begin
                state_d = pending_pkg::BUS_IDLE;
            end
        endcase
        // Held back while masked, not dropped: pend stays set
        mreq_d = |(pend & en_q & pending_pkg::CH_VALID);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q  <= pending_pkg::BUS_IDLE;
            ack_q    <= 1'b0;
            dat_q    <= '0;
            mode_q   <= pending_pkg::MODE_RST;
            pol_q    <= pending_pkg::POL_RST;
            en_q     <= pending_pkg::ENABLE_RST;
            evtmsk_q <= pending_pkg::EVTMSK_RST;
            mreq_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            ack_q    <= ack_d;
            dat_q    <= dat_d;
            mode_q   <= mode_d;
            pol_q    <= pol_d;
            en_q     <= en_d;
            evtmsk_q <= evtmsk_d;
            mreq_q   <= mreq_d;
        end
    end

    assign wb_ack_o               = ack_q;
    assign wb_dat_o               = dat_q;
    assign maskable_request_out_o = mreq_q;

endmodule

// *** hdl/pending_channel.sv ***
module pending_channel (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic src_i,
    input  wire logic mode_i,
    input  wire logic pol_i,
    input  wire logic clr_i,
    output logic      pend_o,
    output logic      edge_o,
    output logic      ovr_o
);

    logic active;
    logic prev_q;
    logic prev_d;
    logic pend_q;
    logic pend_d;
    logic edge_q;
    logic edge_d;
    logic ovr_q;
    logic ovr_d;
    logic hit;
    logic arm_q;
    logic arm_d;

    assign active = src_i ^ pol_i;

    always_comb begin
        prev_d = active;
        arm_d  = 1'b1;
        // History is not valid in the first cycle after reset; a source idling
        // active there must not look like an edge
        hit    = active & ~prev_q & arm_q;
        edge_d = 1'b0;
        ovr_d  = 1'b0;
        if (!mode_i) begin
            pend_d = active;
        end else begin
            // Set beats clear so a new edge in the clearing cycle survives
            pend_d = hit | (pend_q & ~clr_i);
            edge_d = hit;
            ovr_d  = hit & pend_q & ~clr_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            arm_q  <= 1'b0;
            pend_q <= 1'b0;
            edge_q <= 1'b0;
            ovr_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            arm_q  <= arm_d;
            pend_q <= pend_d;
            edge_q <= edge_d;
            ovr_q  <= ovr_d;
        end
    end

    assign pend_o = pend_q;
    assign edge_o = edge_q;
    assign ovr_o  = ovr_q;

endmodule

// *** include/pending_pkg.sv ***
// Function
// - Status bits show pending state regardless of the channel mask.
// - Status bytes 0..3 hold channels 7..1, 15..8, 23..16, 31..24; bit 0 reads zero.
// - A read returns 1 for a pending channel and 0 otherwise.
// - Edge mode: writing 1 clears the status bit, writing 0 does nothing.
// - Level mode: status bit is read-only; written ones are ignored.
// - Level mode follows active source level; edge mode latches until cleared.
// - Mode bit 0 means level-triggered, 1 means edge-triggered.
// - Polarity 0 selects high level or rising edge, 1 low level or falling.
// - Masked pending channels are held back and request once enabled.
package pending_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int unsigned NUM_CH   = 32;
    localparam int unsigned ADR_W    = 8;
    localparam int unsigned DAT_W    = 32;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned EVT_W    = 2;

    // ****************************************
    // Register indices (byte address is four times the index)
    // ****************************************
    localparam logic [5:0] IDX_STAT0   = 6'h00;
    localparam logic [5:0] IDX_STAT1   = 6'h01;
    localparam logic [5:0] IDX_STAT2   = 6'h02;
    localparam logic [5:0] IDX_STAT3   = 6'h03;
    localparam logic [5:0] IDX_MODE    = 6'h04;
    localparam logic [5:0] IDX_POL     = 6'h05;
    localparam logic [5:0] IDX_ENABLE  = 6'h06;
    localparam logic [5:0] IDX_EVT     = 6'h07;
    localparam logic [5:0] IDX_EVTMSK  = 6'h08;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int unsigned EVT_EDGE_POS = 0;
    localparam int unsigned EVT_OVR_POS  = 1;
    localparam logic [31:0] MODE_RST     = 32'h4c1d_0000;
    localparam logic [31:0] POL_RST      = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST   = 32'h0000_0000;
    localparam logic [31:0] CH_VALID     = 32'hffff_fffe;
    localparam logic [1:0]  EVTMSK_RST   = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } wb_req_t;

endpackage

// *** tb/fw_core.sv ***
module fw_core (
    input  wire logic            clk_i,
    input  wire logic            wb_ack_i,
    output pending_pkg::wb_req_t req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Firmware bus master
    // ********
    logic [39:0] exp_q[$];
    initial req_o = '0;
    // Held until the edge that samples ack; released lines show inverted junk
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        req_o <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        req_o <= '{1'b0, 1'b0, 1'b0, ~adr, 4'h0, ~dat};
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] x);
        exp_q.push_back({adr, x});
        bus(1'b0, adr, 32'h0);
    endtask
endmodule

// *** tb/pending_status_checker_assertions.sv ***
module pending_status_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        maskable_request_out_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Shadow of enable and event mask
    // ********
    logic [31:0] en_q;
    logic [1:0]  evm_q;
    logic        rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    // Writes land at the ack edge, as in the block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q  <= '0;
            evm_q <= '0;
        end else if (wb_ack_o && wb_we_i) begin
            if (wb_adr_i[7:2] == 6'h06) en_q <= wb_dat_i;
            if (wb_adr_i[7:2] == 6'h08) evm_q <= wb_dat_i[1:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_new;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_TIMING:
        assert property (s_new |=> s_ans) else $error("ack not a one cycle answer");
    AST_ACK_CAUSE:
        assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    AST_RESET_QUIET:
        assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == '0
                         && !maskable_request_out_o && !irq_o) else $error("reset not quiet");
    AST_BIT0:
        assert property (rd_ack && wb_adr_i[7:2] == 6'h00 |-> !wb_dat_o[0])
        else $error("status bit 0 not zero");
    AST_UPPER:
        assert property (rd_ack && wb_adr_i[7:4] == 4'h0 |-> wb_dat_o[31:8] == '0)
        else $error("status upper bits not zero");
    AST_REQ_MASKED:
        assert property ((en_q == '0) [*2] |-> !maskable_request_out_o)
        else $error("request while all masked");
    AST_IRQ_MASKED:
        assert property ((evm_q == '0) [*2] |-> !irq_o) else $error("irq while masked");
    AST_DAT_HOLD:
        assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    AST_UNMAPPED:
        assert property (rd_ack && wb_adr_i[7:2] > 6'h08 |-> wb_dat_o == '0)
        else $error("unmapped read not zero");
endmodule

bind interrupt_pending_status_bank pending_status_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .maskable_request_out_o(maskable_request_out_o), .irq_o(irq_o));

// *** tb/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Bench
    // ********
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [31:0]          src   = 32'h0;
    logic [31:0]          pol   = 32'h0f0f_5a5a;
    logic [31:0]          rnd   = 32'h0000_001b;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 req_o;
    logic                 irq_o;
    logic [39:0]          e;
    pending_pkg::wb_req_t req;
    int                   error_cnt = 0;
    int                   n_tests   = 0;
    int                   cyc_cnt   = 0;
    fw_core fw (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .req_o(req));
    interrupt_pending_status_bank uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .interrupt_channel_i(src),
        .maskable_request_out_o(req_o), .irq_o(irq_o));
    initial forever #20 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string w, input logic [31:0] x, input logic [31:0] y);
        n_tests++;
        if (y !== x) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", w, x, y);
        end
    endtask
    task automatic pin(input string w, input logic x, ref logic y);
        @(negedge clk_i);
        check(w, {31'h0, x}, {31'h0, y});
        @(posedge clk_i);
    endtask
    task automatic rd_all(input logic [31:0] x);
        for (int i = 0; i < 4; i++) fw.rd(8'(4 * i), (x >> (8 * i)) & 32'hff);
    endtask
    task automatic clr_all;
        for (int i = 0; i < 4; i++) fw.wr(8'(4 * i), 32'hff);
    endtask
    // Mid-cycle sampling keeps clear of the design's own edge updates
    always @(negedge clk_i) begin
        if (wb_ack_o === 1'b1 && req.we === 1'b0) begin
            e = fw.exp_q.pop_front();
            check($sformatf("reg %h", e[39:32]), e[31:0], wb_dat_o);
        end
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_all(32'h0);
        fw.rd(8'h10, pending_pkg::MODE_RST);
        fw.rd(8'h18, 32'h0);
        fw.rd(8'h40, 32'h0);
        $display("reset test done");
        fw.wr(8'h10, 32'h0);
        fw.wr(8'h14, pol);
        fw.rd(8'h14, pol & pending_pkg::CH_VALID);
        repeat (3) begin
            repeat (32) rnd = lfsr(rnd);
            src <= rnd;
            repeat (2) @(posedge clk_i);
            clr_all();
            rd_all((rnd ^ pol) & pending_pkg::CH_VALID);
        end
        $display("level test done");
        src <= 32'h0;
        repeat (2) @(posedge clk_i);
        fw.wr(8'h10, 32'hffff_ffff);
        clr_all();
        src <= 32'hffff_ffff;
        repeat (3) @(posedge clk_i);
        rd_all(~pol & pending_pkg::CH_VALID);
        src <= 32'h0;
        repeat (3) @(posedge clk_i);
        rd_all(pending_pkg::CH_VALID);
        fw.wr(8'h00, 32'h0f);
        fw.wr(8'h04, 32'h0);
        fw.rd(8'h00, 32'hf0);
        fw.rd(8'h04, 32'hff);
        $display("edge test done");
        pin("mreq", 1'b0, req_o);
        fw.wr(8'h18, 32'h8000_0000);
        pin("mreq", 1'b1, req_o);
        fw.rd(8'h0c, 32'hff);
        fw.wr(8'h0c, 32'h80);
        @(posedge clk_i);
        pin("mreq", 1'b0, req_o);
        $display("mask test done");
        fw.rd(8'h1c, 32'h1);
        fw.rd(8'h1c, 32'h0);
        fw.wr(8'h20, 32'h1);
        clr_all();
        src <= 32'h20;
        repeat (4) @(posedge clk_i);
        pin("irq", 1'b1, irq_o);
        fw.rd(8'h1c, 32'h1);
        @(posedge clk_i);
        pin("irq", 1'b0, irq_o);
        src <= 32'h0;
        @(posedge clk_i);
        fw.rd(8'h00, 32'h20);
        src <= 32'h20;
        repeat (4) @(posedge clk_i);
        // A repeat edge is still a new edge, so the unmasked flag rises too
        pin("irq", 1'b1, irq_o);
        fw.rd(8'h1c, 32'h3);
        $display("event test done");
        print_verdict();
    end
endmodule
